// ### logic/dcpd_pkg.sv
/*
 Constants for the direct control pin decoder: general control bit
 positions, reset values, gain codes and divider codes.
 Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none
package dcpd_pkg;
   // ==========================================================
   // General control register layout
   localparam int          GEN_CTRL_WIDTH  = 8;
   localparam int          BIAS_EN_BIT     = 1;
   localparam int          RX_EN_BIT       = 4;
   localparam int          DIV_SEL_BIT     = 7;
   localparam logic [7:0]  GEN_CTRL_RESET  = 8'h00;
   // ==========================================================
   // Gain codes: attenuation in dB, both stages combined
   localparam int          GAIN_WIDTH      = 5;
   localparam logic [4:0]  GAIN_LOW_DB     = 5'h12;
   localparam logic [4:0]  GAIN_MAX_DB     = 5'h00;
   // ==========================================================
   // Mixer LO divider codes
   localparam logic [2:0]  LO_DIV_TWO      = 3'h2;
   localparam logic [2:0]  LO_DIV_FOUR     = 3'h4;
endpackage
`default_nettype wire

// ### logic/dcpd_pin_sel.sv
/*
 One shared pin: routes its level to the serial function or to the
 direct function. Assumes the select is a static level.
*/
`timescale 1ns/1ns
`default_nettype none
module dcpd_pin_sel #(
   parameter logic SERIAL_IDLE = 1'h0
) (
   input  wire logic pinLevel,
   input  wire logic directMode,
   output logic      serialLevel,
   output logic      directLevel
);
   // ==========================================================
   // Split by mode; unused side parks at a safe idle level
   assign serialLevel = directMode ? SERIAL_IDLE : pinLevel;
   assign directLevel = directMode ? pinLevel : 1'b0;
endmodule
`default_nettype wire

// ### logic/dcpd_direct_control_pin_decoder.sv
/*
 Direct control pin decoder: chooses between the serial control bus
 and direct pin control for three shared pins, and produces the
 effective enables, power mode, LO divider and gain settings.
 Everything below the port list is combinational, so a pin change
 shows on the outputs in the same cycle; ref_clk and rst only pace
 and gate the checks at the foot of the file.
 Assumes pins are synchronous to ref_clk and the serial register
 bank lives outside, reporting its general control byte here and
 obeying registerReset as a level, not as a pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module dcpd_direct_control_pin_decoder (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       serial_disable_n,
   input  wire logic       pinData,
   input  wire logic       pinClock,
   input  wire logic       pinSelect,
   input  wire logic [7:0] serialGenCtrl,
   output logic            serial_data_in,
   output logic            serialBitClock,
   output logic            serial_select_n,
   output logic            registerReset,
   output logic            bias_enable,
   output logic            receive_path_enable,
   output logic            lowPowerMode,
   output logic [2:0]      loDivide,
   output logic [4:0]      firstGainStage,
   output logic [4:0]      second_gain_stage,
   output logic            directModeActive
);
   // ==========================================================
   // Mode decode
   logic       directMode;
   logic       power_down_n;
   logic       lo_divider_select;
   logic       gainPin;
   logic [7:0] genCtrl;
   logic       genBiasBit;
   logic       genRxBit;
   logic       genDivBit;
   logic       divBit;
   logic [4:0] gainTotal;

   // The mode is a plain level; nothing is latched on entry or exit
   assign directMode       = ~serial_disable_n;
   assign directModeActive = directMode;

   // ==========================================================
   // Shared pins, one selector each; chip select idles high
   // A deselected serial side sees an idle bus, so a strap that toggles
   // in direct mode can never clock a false transfer into the registers
   dcpd_pin_sel #(
      .SERIAL_IDLE (1'h0)
   ) uData (
      .pinLevel    (pinData),
      .directMode  (directMode),
      .serialLevel (serial_data_in),
      .directLevel (power_down_n)
   );
   dcpd_pin_sel #(
      .SERIAL_IDLE (1'h0)
   ) uClock (
      .pinLevel    (pinClock),
      .directMode  (directMode),
      .serialLevel (serialBitClock),
      .directLevel (lo_divider_select)
   );
   // Chip select parks high in direct mode so no transfer can start
   dcpd_pin_sel #(
      .SERIAL_IDLE (1'h1)
   ) uSelect (
      .pinLevel    (pinSelect),
      .directMode  (directMode),
      .serialLevel (serial_select_n),
      .directLevel (gainPin)
   );

   // ==========================================================
   // Register bank held reset for as long as direct mode lasts
   // Held reset rather than frozen: leaving direct mode starts the bank
   // from known values instead of whatever the host last wrote
   assign registerReset = directMode;
   assign genCtrl = directMode ? dcpd_pkg::GEN_CTRL_RESET : serialGenCtrl;

   // Named register bits, so the forcing below reads plainly
   assign genBiasBit = genCtrl[dcpd_pkg::BIAS_EN_BIT];
   assign genRxBit   = genCtrl[dcpd_pkg::RX_EN_BIT];
   assign genDivBit  = genCtrl[dcpd_pkg::DIV_SEL_BIT];

   // Enables forced on in direct mode, else from the register
   assign bias_enable         = directMode | genBiasBit;
   assign receive_path_enable = directMode | genRxBit;

   // ==========================================================
   // Direct functions; all combinational so no edge is needed
   // Power-down only acts in direct mode; the bank owns it otherwise
   assign lowPowerMode = directMode & ~power_down_n;
   // Pin is the inverse of bit7: bit7 set means divide by two
   assign divBit   = directMode ? ~lo_divider_select : genDivBit;
   assign loDivide = divBit ? dcpd_pkg::LO_DIV_TWO : dcpd_pkg::LO_DIV_FOUR;
   // Low total placed in first stage only; second stays at maximum
   // Trade-off: splitting the cut across both stages would ease overload
   // but cost noise figure, so the second stage is left at full gain
   assign gainTotal         = gainPin ? dcpd_pkg::GAIN_MAX_DB : dcpd_pkg::GAIN_LOW_DB;
   assign firstGainStage    = directMode ? gainTotal : dcpd_pkg::GAIN_MAX_DB;
   assign second_gain_stage = dcpd_pkg::GAIN_MAX_DB;

   // ==========================================================
   // Checks
   // Every property samples inputs and outputs at the same edges; the decode
   // is combinational, so they must agree there with no cycle of lag.
   // All are quiet while rst is high; rst touches nothing else.

   // ==========================================================
   // Sequences
   // Sequences carry no clock of their own; each assert supplies it
   // Direct mode held over two edges, so a pin change is not confused
   // with the output jump that comes from entering the mode itself
   sequence s_stay_direct;
      (!serial_disable_n) [*2];
   endsequence
   // The edges at which direct mode is entered and left
   sequence s_enter_direct;
      $fell(serial_disable_n);
   endsequence
   sequence s_leave_direct;
      $rose(serial_disable_n);
   endsequence

   // ==========================================================
   // Mode and pin routing
   // Serial side must see the pins untouched, or an idle bus
   a_mode_flag: assert property (@(posedge ref_clk) disable iff (rst)
      directModeActive == !serial_disable_n)
      else $error("mode flag does not follow disable input");
   a_select_park: assert property (@(posedge ref_clk) disable iff (rst)
      !serial_disable_n |-> serial_select_n)
      else $error("chip select active in direct mode");
   a_clock_park: assert property (@(posedge ref_clk) disable iff (rst)
      !serial_disable_n |-> (!serial_data_in && !serialBitClock))
      else $error("serial data or clock active in direct mode");
   a_serial_pass: assert property (@(posedge ref_clk) disable iff (rst)
      serial_disable_n |-> (serial_data_in == pinData && serial_select_n == pinSelect))
      else $error("serial pins not passed through");
   a_clock_pass: assert property (@(posedge ref_clk) disable iff (rst)
      serial_disable_n |-> (serialBitClock == pinClock))
      else $error("serial clock not passed through");

   // ==========================================================
   // Register bank and forced enables
   a_force_enables: assert property (@(posedge ref_clk) disable iff (rst)
      !serial_disable_n |-> (bias_enable && receive_path_enable && registerReset))
      else $error("enables not forced in direct mode");
   a_reg_reset: assert property (@(posedge ref_clk) disable iff (rst)
      registerReset == !serial_disable_n)
      else $error("register reset does not follow mode");
   a_enable_serial: assert property (@(posedge ref_clk) disable iff (rst)
      serial_disable_n |-> (bias_enable == serialGenCtrl[dcpd_pkg::BIAS_EN_BIT] &&
         receive_path_enable == serialGenCtrl[dcpd_pkg::RX_EN_BIT]))
      else $error("enables not taken from register");
   // Entry and exit are checked at the very edge of the strap change
   a_enter_direct: assert property (@(posedge ref_clk) disable iff (rst)
      s_enter_direct |-> (registerReset && bias_enable && receive_path_enable && serial_select_n))
      else $error("direct mode entry incomplete");
   a_leave_direct: assert property (@(posedge ref_clk) disable iff (rst)
      s_leave_direct |-> (!registerReset && serial_select_n == pinSelect))
      else $error("serial mode not restored");

   // ==========================================================
   // Power, divider and gain
   a_power_mode: assert property (@(posedge ref_clk) disable iff (rst)
      !serial_disable_n |-> (lowPowerMode == !pinData))
      else $error("power mode mismatch");
   a_serial_power: assert property (@(posedge ref_clk) disable iff (rst)
      serial_disable_n |-> !lowPowerMode)
      else $error("low power asserted in serial mode");
   // The divider pin and bit 7 are checked against opposite senses
   a_divider_sel: assert property (@(posedge ref_clk) disable iff (rst)
      !serial_disable_n |-> (loDivide == (pinClock ? dcpd_pkg::LO_DIV_FOUR : dcpd_pkg::LO_DIV_TWO)))
      else $error("divider mismatch");
   a_divider_inv: assert property (@(posedge ref_clk) disable iff (rst)
      serial_disable_n |-> (loDivide == (serialGenCtrl[dcpd_pkg::DIV_SEL_BIT] ?
         dcpd_pkg::LO_DIV_TWO : dcpd_pkg::LO_DIV_FOUR)))
      else $error("serial divider mismatch");
   // Gain codes are attenuation, so maximum gain is code zero
   a_gain_low: assert property (@(posedge ref_clk) disable iff (rst)
      (!serial_disable_n && !pinSelect) |-> (firstGainStage + second_gain_stage == dcpd_pkg::GAIN_LOW_DB))
      else $error("low gain wrong");
   a_gain_split: assert property (@(posedge ref_clk) disable iff (rst)
      (!serial_disable_n && !pinSelect) |-> (second_gain_stage == dcpd_pkg::GAIN_MAX_DB))
      else $error("low gain not kept on first stage");
   a_gain_max: assert property (@(posedge ref_clk) disable iff (rst)
      (!serial_disable_n && pinSelect) |-> (firstGainStage == dcpd_pkg::GAIN_MAX_DB &&
         second_gain_stage == dcpd_pkg::GAIN_MAX_DB))
      else $error("max gain wrong");
   a_serial_gain: assert property (@(posedge ref_clk) disable iff (rst)
      serial_disable_n |-> (firstGainStage == dcpd_pkg::GAIN_MAX_DB &&
         second_gain_stage == dcpd_pkg::GAIN_MAX_DB))
      else $error("gain cut applied in serial mode");

   // ==========================================================
   // Outputs track pin changes inside the same cycle
   // Each pin is checked only while direct mode stands on both edges
   a_level_follow: assert property (@(posedge ref_clk) disable iff (rst)
      s_stay_direct ##0 $changed(pinData) |-> $changed(lowPowerMode))
      else $error("output lagged pin");
   a_divider_follow: assert property (@(posedge ref_clk) disable iff (rst)
      s_stay_direct ##0 $changed(pinClock) |-> $changed(loDivide))
      else $error("divider lagged pin");
   a_gain_follow: assert property (@(posedge ref_clk) disable iff (rst)
      s_stay_direct ##0 $changed(pinSelect) |-> $changed(firstGainStage))
      else $error("gain lagged pin");
endmodule
`default_nettype wire

// ### bench/dcpd_pin_host.sv
/*
 Host model that straps the shared pins and the serial-disable line.
 Assumes requests change on a ref_clk edge; levels move on the next edge.
*/
`timescale 1ns/1ns
`default_nettype none
module dcpd_pin_host (
   input  wire logic       ref_clk,
   input  wire logic       modeReq,
   input  wire logic [2:0] pinReq,
   output var  logic       serial_disable_n,
   output var  logic [2:0] pinBus
);
   // ==========================================
   // Pin straps
   // Disable line starts high, as its pull-up leaves it when unstrapped
   initial begin
      serial_disable_n = 1'b1;
      pinBus = 3'h5;
   end
   // Straps change only on the clock, so the decoder sees static levels
   always @(posedge ref_clk) begin
      serial_disable_n <= modeReq;
      pinBus <= pinReq;
   end
endmodule
`default_nettype wire

// ### bench/dcpd_direct_control_pin_decoder_test.sv
/*
 Testbench: walks every pin level in serial and direct mode and checks outputs.
 Assumes a purely combinational decoder fed by the host model.
*/
`timescale 1ns/1ns
`default_nettype none
module dcpd_direct_control_pin_decoder_test;
   logic ref_clk = 1'b0, rst = 1'b1, modeReq = 1'b1;
   logic [2:0] pinReq = 3'h0;
   logic [7:0] genCtrl = 8'h00;
   wire logic sdn, sdi, sbc, ssn, rr, be, rx, lp, dm;
   wire logic [2:0] pinBus, lod;
   wire logic [4:0] g1, g2;
   int n_fail = 0, check_count = 0;
   // ==========================================
   // Clock, parts and helpers
   always #5 ref_clk = ~ref_clk;
   dcpd_pin_host dcpd_pin_host_i (.ref_clk(ref_clk), .modeReq(modeReq), .pinReq(pinReq),
      .serial_disable_n(sdn), .pinBus(pinBus));
   dcpd_direct_control_pin_decoder dcpd_direct_control_pin_decoder_i (.ref_clk(ref_clk), .rst(rst),
      .serial_disable_n(sdn), .pinData(pinBus[0]), .pinClock(pinBus[1]), .pinSelect(pinBus[2]),
      .serialGenCtrl(genCtrl), .serial_data_in(sdi), .serialBitClock(sbc), .serial_select_n(ssn),
      .registerReset(rr), .bias_enable(be), .receive_path_enable(rx), .lowPowerMode(lp),
      .loDivide(lod), .firstGainStage(g1), .second_gain_stage(g2), .directModeActive(dm));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want) begin
         n_fail++;
         $display("BAD %0t outputs %h expected %h", $time, seen, want);
      end
   endtask
   // Host needs one edge to take the strap, then outputs settle at once
   task automatic drive(input logic mode, input logic [2:0] pins, input logic [7:0] gc);
      @(posedge ref_clk);
      modeReq <= mode;
      pinReq <= pins;
      genCtrl <= gc;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic test_done;
      if (n_fail == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         drive(1'b1, i[2:0], {i[2], 2'b00, i[1], 2'b00, i[0], 1'b0});
         check({sdi, sbc, ssn, rr, be, rx, lp, dm}, {i[0], i[1], i[2], 5'h00} | {4'h0, i[0], i[1], 2'b00});
         check({lod, g1 | g2}, {i[2] ? dcpd_pkg::LO_DIV_TWO : dcpd_pkg::LO_DIV_FOUR, 5'h00});
      end
      // Register bits copy the divider pin, so a bank leaking past its
      // reset would flip the divider or mask a forced enable
      for (int i = 0; i < 8; i++) begin
         drive(1'b0, i[2:0], {8{i[1]}});
         check({sdi, sbc, ssn, rr, be, rx, dm}, 7'h1f);
         check(lp, !i[0]);
         check(g2, dcpd_pkg::GAIN_MAX_DB);
         check(lod, i[1] ? dcpd_pkg::LO_DIV_FOUR : dcpd_pkg::LO_DIV_TWO);
         check(g1, i[2] ? dcpd_pkg::GAIN_MAX_DB : dcpd_pkg::GAIN_LOW_DB);
      end
      // Leaving direct mode releases the bank and hands the pins back
      drive(1'b1, 3'h3, 8'h92);
      check({ssn, rr, be, rx, lod}, {4'h3, dcpd_pkg::LO_DIV_TWO});
      test_done();
   end
   // Whole run is about 60 cycles; this leaves wide margin
   initial begin
      #3000;
      n_fail++;
      test_done();
   end
endmodule
`default_nettype wire
